// File: src/scan_pkg.sv
/*
 * constants, field positions, reset values and state type of the frequency-scan
 * control block.
 * assumes: one master clock domain (pclk); all pins except the apb bus reach it through synchronisers.
 */
package scan_pkg;

    // ----------------------------------------------------------------
    // datapath widths and fixed values
    // ----------------------------------------------------------------
    localparam int          FREQ_W    = 24;
    localparam int          DAC_W     = 10;
    localparam int          WORD_BITS = 16;
    localparam logic [9:0]  MIDSCALE  = 10'h200;
    localparam logic [4:0]  LAST_BIT  = 5'h0F;

    // ----------------------------------------------------------------
    // serial word target codes (top four bits; the interval code is the top two)
    // ----------------------------------------------------------------
    localparam logic [3:0]  ADDR_CFG      = 4'h0;
    localparam logic [3:0]  ADDR_NINCR    = 4'h1;
    localparam logic [3:0]  ADDR_STEP_LO  = 4'h2;
    localparam logic [3:0]  ADDR_STEP_HI  = 4'h3;
    localparam logic [1:0]  ADDR_INTERVAL = 2'h1;
    localparam logic [3:0]  ADDR_START_LO = 4'hC;
    localparam logic [3:0]  ADDR_START_HI = 4'hD;

    // ----------------------------------------------------------------
    // configuration word bit positions and reset value
    // ----------------------------------------------------------------
    localparam int          CFG_EXT_INCR   = 5;
    localparam int          CFG_SIGN_OE    = 8;
    localparam int          CFG_STATUS_OE  = 9;
    localparam int          CFG_STATUS_SRC = 10;
    localparam logic [11:0] CFG_RESET      = 12'h000;

    // ----------------------------------------------------------------
    // synchroniser lanes and their reset levels
    // ----------------------------------------------------------------
    localparam int          SYNC_W    = 6;
    localparam int          IN_DIN    = 0;
    localparam int          IN_FS     = 1;
    localparam int          IN_SCLK   = 2;
    localparam int          IN_TRIG   = 3;
    localparam int          IN_ABORT  = 4;
    localparam int          IN_STBY   = 5;
    localparam logic [5:0]  SYNC_RST  = 6'h06;   // frame and serial clock idle high

    // ----------------------------------------------------------------
    // apb register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]  REG_CONTROL = 8'h00;
    localparam logic [7:0]  REG_STATUS  = 8'h04;
    localparam logic [7:0]  REG_FREQ    = 8'h08;
    localparam logic [7:0]  REG_CONFIG  = 8'h0C;
    localparam logic [7:0]  REG_WORD    = 8'h10;
    localparam int          CTL_ABORT   = 0;
    localparam int          CTL_START   = 1;

    typedef enum logic [1:0] {S_IDLE, S_RUN, S_HOLD} scan_state_t;

endpackage

// File: src/edge_sync.sv
/*
 * multi-lane two flip-flop synchroniser with edge detection.
 * assumes: inputs are asynchronous to clk; edges are wider than two clk periods.
 */
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    // ----------------------------------------------------------------
    // shift chain: s1 feeds only s2, edges compare s2 with s3
    // ----------------------------------------------------------------
    always_comb
    begin
        d    = q;
        d.s1 = din;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= {RST_VAL, RST_VAL, RST_VAL};
        else
            q <= d;
    end

    // edge outputs from the settled stages only
    assign level = q.s2;
    assign rise  = q.s2 & ~q.s3;
    assign fall  = ~q.s2 & q.s3;

endmodule
`default_nettype wire

// File: src/freq_scan_core.sv
/*
 * frequency-scan control: serial word loader, scan state machine, phase
 * accumulator, dac code, status and sign outputs, apb register slave.
 * assumes: all pins except the apb bus are asynchronous to pclk and slow against it.
 */
`timescale 1ns/1ps
`default_nettype none
module freq_scan_core #(
    parameter int ADDR_W = 8
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      sclk,
    input  wire logic                      frame_sync_n,
    input  wire logic                      serial_din,
    input  wire logic                      scan_trigger,
    input  wire logic                      abort_in,
    input  wire logic                      standby,
    output logic      [scan_pkg::DAC_W-1:0] dac_code,
    output logic                           scan_status_out,
    output logic                           scan_status_oe,
    output logic                           sign_bit_out,
    output logic                           sign_bit_oe
);
    import scan_pkg::*;

    typedef struct packed {
        scan_state_t       fsm;
        logic [FREQ_W-1:0] phase;
        logic [FREQ_W-1:0] freq;
        logic [FREQ_W-1:0] start;
        logic [FREQ_W-1:0] step;
        logic [11:0]       cfg;
        logic [11:0]       nincr;
        logic [11:0]       count;
        logic [13:0]       interval;
        logic [13:0]       timer;
        logic [4:0]        bitcnt;
        logic [15:0]       shreg;
        logic [15:0]       last_word;
        logic [DAC_W-1:0]  dac;
        logic              status_out;
        logic              status_oe;
        logic              sign_out;
        logic              sign_oe;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } core_state_t;

    core_state_t       q;
    core_state_t       d;
    logic [SYNC_W-1:0] s_lvl;
    logic [SYNC_W-1:0] s_rise;
    logic [SYNC_W-1:0] s_fall;
    logic              word_done;
    logic [15:0]       word;
    logic              reset_req;
    logic              trig_evt;
    logic              step_evt;
    logic              inc_pulse;
    logic              soft_abort;
    logic              soft_start;
    logic              apb_write;
    logic [DAC_W-1:0]  dac_next;
    logic [13:0]       dwell;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    edge_sync #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .din   ({standby, abort_in, scan_trigger, sclk, frame_sync_n, serial_din}),
        .level (s_lvl),
        .rise  (s_rise),
        .fall  (s_fall)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        d          = q;
        word_done  = 1'b0;
        word       = {q.shreg[14:0], s_lvl[IN_DIN]};
        step_evt   = 1'b0;
        inc_pulse  = 1'b0;
        dac_next   = q.dac;
        dwell      = (q.interval == 14'h0000) ? 14'h0000 : q.interval - 14'h0001;
        apb_write  = psel && penable && q.pready && pwrite && !q.pslverr;
        soft_abort = apb_write && (paddr == ADDR_W'(REG_CONTROL)) && pwdata[CTL_ABORT];
        soft_start = apb_write && (paddr == ADDR_W'(REG_CONTROL)) && pwdata[CTL_START];
        trig_evt   = s_rise[IN_TRIG] || soft_start;
        reset_req  = 1'b0;

        // apb setup cycle: answer in the first access cycle
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        if (psel && !penable)
        begin
            d.pready = 1'b1;
            if (paddr == ADDR_W'(REG_CONTROL))
                d.prdata = 32'h0000_0000;
            else if (paddr == ADDR_W'(REG_STATUS))
                d.prdata = {14'h0000, q.fsm, 4'h0, q.count};
            else if (paddr == ADDR_W'(REG_FREQ))
                d.prdata = {8'h00, q.freq};
            else if (paddr == ADDR_W'(REG_CONFIG))
                d.prdata = {20'h0_0000, q.cfg};
            else if (paddr == ADDR_W'(REG_WORD))
                d.prdata = {16'h0000, q.last_word};
            else
            begin
                d.prdata  = 32'h0000_0000;
                d.pslverr = 1'b1;
            end
        end

        // everything below stands still while standby is high
        if (!s_lvl[IN_STBY])
        begin
            // serial loader: frame high clears the bit counter
            if (s_lvl[IN_FS])
                d.bitcnt = 5'h00;
            else if (s_fall[IN_SCLK])
            begin
                d.shreg = word;
                if (q.bitcnt == LAST_BIT)
                begin
                    word_done = 1'b1;
                    d.bitcnt  = 5'h00;
                end
                else
                    d.bitcnt = q.bitcnt + 5'h01;
            end

            // word decode by the top four bits; the interval by the top two
            if (word_done)
            begin
                d.last_word = word;
                if (word[15:12] == ADDR_CFG)
                begin
                    d.cfg     = word[11:0];
                    reset_req = 1'b1;
                end
                else if (word[15:12] == ADDR_NINCR)
                    d.nincr = word[11:0];
                else if (word[15:12] == ADDR_STEP_LO)
                    d.step[11:0] = word[11:0];
                else if (word[15:12] == ADDR_STEP_HI)
                    d.step[23:12] = word[11:0];
                else if (word[15:14] == ADDR_INTERVAL)
                    d.interval = word[13:0];
                else if (word[15:12] == ADDR_START_LO)
                    d.start[11:0] = word[11:0];
                else if (word[15:12] == ADDR_START_HI)
                    d.start[23:12] = word[11:0];
            end

            if (s_rise[IN_ABORT] || soft_abort)
                reset_req = 1'b1;

            // scan state machine; reset wins over trigger
            case (q.fsm)
                S_RUN:
                begin
                    if (q.cfg[CFG_EXT_INCR])
                        step_evt = s_rise[IN_TRIG];
                    else if (q.timer == 14'h0000)
                    begin
                        step_evt = 1'b1;
                        d.timer  = dwell;
                    end
                    else
                        d.timer = q.timer - 14'h0001;
                end
                default:
                begin
                    if (trig_evt)
                    begin
                        d.freq  = q.start;
                        d.count = 12'h000;
                        d.timer = dwell;
                        d.fsm   = (q.nincr == 12'h000) ? S_HOLD : S_RUN;
                    end
                end
            endcase

            if (step_evt)
            begin
                d.freq    = q.freq + q.step;
                d.count   = q.count + 12'h001;
                inc_pulse = 1'b1;
                if (q.count + 12'h001 == q.nincr)
                    d.fsm = S_HOLD;
            end

            if (reset_req)
            begin
                d.fsm   = S_IDLE;
                d.count = 12'h000;
                d.timer = 14'h0000;
            end

            // phase accumulator and dac code; idle forces midscale
            if (q.fsm == S_IDLE)
            begin
                d.phase  = '0;
                dac_next = MIDSCALE;
            end
            else
            begin
                d.phase  = q.phase + q.freq;
                dac_next = q.phase[FREQ_W-1 -: DAC_W];
            end
            d.dac = dac_next;

            // gated digital outputs
            d.status_oe  = q.cfg[CFG_STATUS_OE];
            d.status_out = q.cfg[CFG_STATUS_OE]
                         & (q.cfg[CFG_STATUS_SRC] ? inc_pulse : (q.fsm == S_HOLD));
            d.sign_oe    = q.cfg[CFG_SIGN_OE];
            d.sign_out   = q.cfg[CFG_SIGN_OE] & ~dac_next[DAC_W-1];
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q           <= '0;
            q.fsm       <= S_IDLE;
            q.cfg       <= CFG_RESET;
            q.dac       <= MIDSCALE;
        end
        else
            q <= d;
    end

    // outputs straight from flops
    assign prdata          = q.prdata;
    assign pready          = q.pready;
    assign pslverr         = q.pslverr;
    assign dac_code        = q.dac;
    assign scan_status_out = q.status_out;
    assign scan_status_oe  = q.status_oe;
    assign sign_bit_out    = q.sign_out;
    assign sign_bit_oe     = q.sign_oe;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    abort_resets_a: assert property ((s_rise[IN_ABORT] && !s_lvl[IN_STBY]) |=> q.fsm == S_IDLE)
        else $error("abort edge did not return scan to idle");
    idle_midscale_a: assert property ((q.fsm == S_IDLE && !s_lvl[IN_STBY]) |=> dac_code == MIDSCALE)
        else $error("dac code not midscale while idle");
    sign_bit_a: assert property (sign_bit_oe |-> sign_bit_out == !dac_code[DAC_W-1])
        else $error("sign output is not inverted dac msb");
    sign_gate_a: assert property (!sign_bit_oe |-> !sign_bit_out)
        else $error("sign output active while disabled");
    status_gate_a: assert property (!scan_status_oe |-> !scan_status_out)
        else $error("status output active while disabled");
    start_scan_a: assert property ((trig_evt && q.fsm != S_RUN && !reset_req && !s_lvl[IN_STBY])
        |=> (q.fsm != S_IDLE && q.count == 12'h000 && q.freq == $past(q.start)))
        else $error("trigger did not start scan at start frequency");
    ext_step_a: assert property ((q.fsm == S_RUN && q.cfg[CFG_EXT_INCR] && s_rise[IN_TRIG]
        && !reset_req && !s_lvl[IN_STBY]) |=> q.count == $past(q.count) + 12'h001)
        else $error("external edge did not advance one step");
    auto_step_a: assert property ((q.fsm == S_RUN && !q.cfg[CFG_EXT_INCR] && q.timer == 14'h0000
        && !reset_req && !s_lvl[IN_STBY]) |=> q.freq == $past(q.freq) + $past(q.step))
        else $error("auto interval expiry did not step frequency");
    hold_freq_a: assert property ((q.fsm == S_HOLD && !trig_evt) |=> $stable(q.freq))
        else $error("held frequency changed");
    word_len_a: assert property (word_done
        |=> (q.bitcnt == 5'h00 && q.last_word == $past(word)))
        else $error("word end did not store word and restart bit count");
    bit_capture_a: assert property ((s_fall[IN_SCLK] && !s_lvl[IN_FS] && !s_lvl[IN_STBY])
        |=> q.shreg[0] == $past(s_lvl[IN_DIN]))
        else $error("serial bit not captured on falling edge");
    cfg_reset_a: assert property ((word_done && word[15:12] == ADDR_CFG)
        |=> q.fsm == S_IDLE)
        else $error("configuration write did not reset scan");
    standby_freeze_a: assert property (s_lvl[IN_STBY] |=> ($stable(q.phase) && $stable(q.fsm)))
        else $error("scan logic moved in standby");

    scan_done_c: cover property (q.fsm == S_RUN ##1 q.fsm == S_HOLD);
    ext_incr_c: cover property (q.cfg[CFG_EXT_INCR] && step_evt);
    abort_mid_c: cover property (q.fsm == S_RUN && s_rise[IN_ABORT]);
    multi_word_c: cover property (word_done ##[1:300] word_done && !s_lvl[IN_FS]);

endmodule
`default_nettype wire

// File: sim/serial_host.sv
/*
 * host model driving the three-wire serial port of the scan block.
 * assumes: pclk is the 25 MHz master clock; sclk runs at 320 ns only in frames.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_host (
    input  wire logic pclk,
    output logic      sclk,
    output logic      frame_sync_n,
    output logic      serial_din
);
    // --------------------------------------------------------------
    // idle levels: clock stands high, frame inactive
    // --------------------------------------------------------------
    initial
    begin
        sclk         = 1'b1;
        frame_sync_n = 1'b1;
        serial_din   = 1'b0;
    end

    // send nbits from the top of w; 16 or 32 whole words, less to abort a word
    task automatic send(input logic [31:0] w, input int nbits);
        @(posedge pclk);
        frame_sync_n <= 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            serial_din <= w[31-i];
            repeat (4) @(posedge pclk);
            sclk <= 1'b0;
            repeat (4) @(posedge pclk);
            sclk <= 1'b1;
        end
        repeat (4) @(posedge pclk);
        frame_sync_n <= 1'b1;
        serial_din   <= ~serial_din;
    endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
/*
 * self-checking bench of freq_scan_core: apb tasks, serial host, pin pulses.
 * assumes: scan_pkg and the design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import scan_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    wire         sclk;
    wire         frame_sync_n;
    wire         serial_din;
    logic        scan_trigger;
    logic        abort_in;
    logic        standby;
    logic [9:0]  dac_code;
    logic        scan_status_out;
    logic        scan_status_oe;
    logic        sign_bit_out;
    logic        sign_bit_oe;
    int          fails;
    int          n_compared;
    int          cycles = 0;
    int          pulses = 0;
    int          pulses_base;
    logic        st_last = 1'b0;

    // --------------------------------------------------------------
    // design, host model, clock and reset
    // --------------------------------------------------------------
    freq_scan_core #(.ADDR_W(8)) freq_scan_core_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk(sclk),
        .frame_sync_n(frame_sync_n), .serial_din(serial_din),
        .scan_trigger(scan_trigger), .abort_in(abort_in), .standby(standby),
        .dac_code(dac_code), .scan_status_out(scan_status_out),
        .scan_status_oe(scan_status_oe), .sign_bit_out(sign_bit_out),
        .sign_bit_oe(sign_bit_oe)
    );
    serial_host serial_host_i (
        .pclk(pclk), .sclk(sclk), .frame_sync_n(frame_sync_n), .serial_din(serial_din)
    );
    always #20 pclk = ~pclk;

    // cycle ceiling and per-increment status pulse counter
    always @(posedge pclk)
    begin
        cycles  <= cycles + 1;
        st_last <= scan_status_out;
        if (scan_status_out === 1'b1 && st_last === 1'b0)
            pulses <= pulses + 1;
        if (cycles == 20000)
        begin
            fails = fails + 1;
            print_verdict();
        end
    end

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic print_verdict();
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            fails = fails + 1;
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask

    // read, mask and compare data and error response
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                       input logic ee);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, d, e);
        chk("prdata", exp, d & m);
        chk("pslverr", {31'h0, ee}, {31'h0, e});
    endtask

    // one clean rising edge on the trigger (0) or abort (1) pin
    task automatic pulse(input int which);
        @(posedge pclk);
        if (which == 0) scan_trigger <= 1'b1;
        else abort_in <= 1'b1;
        repeat (6) @(posedge pclk);
        scan_trigger <= 1'b0;
        abort_in     <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, scan_trigger, abort_in, standby} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        fails = 0;
        n_compared = 0;
        pulses_base = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk("dac_code", {22'h0, MIDSCALE}, {22'h0, dac_code});
        chk("oe", 32'h0000_0000, {30'h0, scan_status_oe, sign_bit_oe});
        rdc(REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
        rdc(REG_CONFIG, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
        rdc(8'h14, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
        // auto scan: start 0x400100, step 0x10, three steps, dwell 64
        serial_host_i.send({16'h0300, 16'h0000}, 16);
        serial_host_i.send({16'hC100, 16'hD400}, 32);
        serial_host_i.send({16'h2010, 16'h3000}, 32);
        serial_host_i.send({16'h1003, 16'h4040}, 32);
        serial_host_i.send({16'h1007, 16'h0000}, 8);
        rdc(REG_WORD, 32'h0000_FFFF, 32'h0000_4040, 1'b0);
        rdc(REG_CONFIG, 32'h0000_0FFF, 32'h0000_0300, 1'b0);
        chk("oe", 32'h0000_0003, {30'h0, scan_status_oe, sign_bit_oe});
        pulse(0);
        rdc(REG_STATUS, 32'h0003_0000, 32'h0001_0000, 1'b0);
        chk("status", 32'h0000_0000, {31'h0, scan_status_out});
        repeat (300) @(posedge pclk);
        rdc(REG_STATUS, 32'h0003_0000, 32'h0002_0000, 1'b0);
        rdc(REG_FREQ, 32'h00FF_FFFF, 32'h0040_0130, 1'b0);
        chk("status", 32'h0000_0001, {31'h0, scan_status_out});
        for (int i = 0; i < 8; i++)
        begin
            @(negedge pclk);
            chk("sign", {31'h0, ~dac_code[9]}, {31'h0, sign_bit_out});
        end
        // external mode, per-increment status; config write resets the scan
        serial_host_i.send({16'h0720, 16'h0000}, 16);
        rdc(REG_STATUS, 32'h0003_0000, 32'h0000_0000, 1'b0);
        chk("dac_code", {22'h0, MIDSCALE}, {22'h0, dac_code});
        pulse(0);
        pulses_base = pulses;
        pulse(0);
        pulse(0);
        rdc(REG_FREQ, 32'h00FF_FFFF, 32'h0040_0120, 1'b0);
        chk("pulses", 32'h0000_0002, pulses - pulses_base);
        pulse(1);
        rdc(REG_STATUS, 32'h0003_0000, 32'h0000_0000, 1'b0);
        chk("dac_code", {22'h0, MIDSCALE}, {22'h0, dac_code});
        // soft start and soft abort through the control register
        wr(REG_CONTROL, 32'h0000_0002);
        rdc(REG_STATUS, 32'h0003_0000, 32'h0001_0000, 1'b0);
        wr(REG_CONTROL, 32'h0000_0001);
        rdc(REG_CONTROL, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
        rdc(REG_STATUS, 32'h0003_0000, 32'h0000_0000, 1'b0);
        // standby freezes the serial loader
        @(posedge pclk);
        standby <= 1'b1;
        repeat (6) @(posedge pclk);
        serial_host_i.send({16'h1005, 16'h0000}, 16);
        standby <= 1'b0;
        rdc(REG_WORD, 32'h0000_FFFF, 32'h0000_0720, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
